// [core/ccs_pkg.sv]
`default_nettype none
package ccs_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on the APB)
  // ----------------------------------------------------------------
  localparam int unsigned     APB_AW   = 12;
  localparam logic [11:0]     OFF_CS0  = 12'h000;
  localparam logic [11:0]     OFF_ERR  = 12'h004;
  localparam logic [11:0]     OFF_IST  = 12'h008;
  localparam logic [11:0]     OFF_IMSK = 12'h00C;
  localparam logic [11:0]     OFF_TMR  = 12'h010;

  // ----------------------------------------------------------------
  // Field positions of can_control_status_0
  // ----------------------------------------------------------------
  localparam int unsigned     BIT_FRM  = 7;
  localparam int unsigned     BIT_RXA  = 6;
  localparam int unsigned     BIT_SIW  = 5;
  localparam int unsigned     BIT_SYN  = 4;
  localparam int unsigned     BIT_TEN  = 3;
  localparam int unsigned     BIT_WUP  = 2;
  localparam int unsigned     BIT_INI  = 1;
  localparam int unsigned     BIT_SLP  = 0;

  // ----------------------------------------------------------------
  // Interrupt status and mask layout
  // ----------------------------------------------------------------
  localparam int unsigned     IRQ_W    = 3;
  localparam int unsigned     IRQ_FRM  = 0;
  localparam int unsigned     IRQ_WAKE = 1;
  localparam int unsigned     IRQ_TS   = 2;

  // ----------------------------------------------------------------
  // Reset values, widths and buffer byte positions
  // ----------------------------------------------------------------
  localparam logic            CTL_RST  = 1'h0;
  localparam logic [2:0]      IMSK_RST = 3'h0;
  localparam int unsigned     TMR_W    = 16;
  localparam int unsigned     ERR_W    = 8;
  localparam logic [3:0]      TS_BYTE_HI = 4'hE;
  localparam logic [3:0]      TS_BYTE_LO = 4'hF;

  typedef enum logic [1:0] {MD_RUN, MD_INIT, MD_SLEEP} ccs_mode_t;

endpackage
`default_nettype wire

// [core/ccs_tmr_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface ccs_tmr_if;
  logic                        en;
  logic                        tick;
  logic [ccs_pkg::TMR_W-1:0]   cnt;
  modport ctl (output en, output tick, input cnt);
  modport tmr (input en, input tick, output cnt);
endinterface
`default_nettype wire

// [core/ccs_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module ccs_timer (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  ce,
  ccs_tmr_if.tmr     tif
);

  typedef struct packed {
    logic [ccs_pkg::TMR_W-1:0] cnt;
  } ccs_tmr_st_t;

  ccs_tmr_st_t st_r;
  ccs_tmr_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (!tif.en)
    begin
      st_nxt.cnt = '0; // see R10
    end
    else if (tif.tick)
    begin
      st_nxt.cnt = st_r.cnt + 16'h0001; // see R07
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

  assign tif.cnt = st_r.cnt;

  tmr_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // see R10
    (ce && !tif.en) |=> (tif.cnt == 16'h0000))
    else $error("Timestamp counter not cleared while disabled.");

  tmr_step_a: assert property (@(posedge clk) disable iff (!rst_n) // see R07
    (ce && tif.en && tif.tick && $past(tif.en)) |=> (tif.cnt == $past(tif.cnt) + 16'h0001))
    else $error("Timestamp counter did not advance on a bit tick.");

endmodule
`default_nettype wire

// [core/ccs_sticky.sv]
`timescale 1ns/10ps
`default_nettype none
module ccs_sticky #(
  parameter int unsigned W = 1
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic          hold,
  input  wire logic [W-1:0]  set,
  input  wire logic [W-1:0]  clr,
  output logic      [W-1:0]  flags
);

  typedef struct packed {
    logic [W-1:0] flags;
  } ccs_stk_st_t;

  ccs_stk_st_t st_r;
  ccs_stk_st_t st_nxt;

  // A set in the same cycle as a clear wins, so no event is lost.
  always_comb
  begin
    st_nxt = st_r;
    if (hold)
      st_nxt.flags = '0;
    else
      st_nxt.flags = (st_r.flags & ~clr) | set;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

  assign flags = st_r.flags;

  set_wins_a: assert property (@(posedge clk) disable iff (!rst_n) // see R02
    (ce && !hold && (set != '0)) |=> ((flags & $past(set)) == $past(set)))
    else $error("Sticky flag lost an event.");

endmodule
`default_nettype wire

// [core/ccs_top.sv]
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
// Contract
// R01: Set frame-received flag on every correctly received valid message.
// R02: Frame-received flag stays set until reset or a written one.
// R03: Receiver-active flag reads one while receiving, zero when idle or sending.
// R04: In loopback the frame and receiver-active flags carry no meaning.
// R05: Stop-in-wait set stops bus-interface clocks during wait mode.
// R06: Synchronized flag reads one only while synchronized to the bus.
// R07: Timer enable starts a free-running 16-bit bit-clock counter.
// R08: After each valid frame end, store timestamp in the buffer's top bytes.
// R09: No receive timestamp is written in loopback.
// R10: Clearing timer enable resets the counter to zero.
// R11: Timer enable is forced low throughout initialization mode.
// R12: Wake-up enable lets bus traffic restart the controller from sleep.
// R13: Software sets wake-up enable before requesting sleep.
// R14: In init mode the register holds reset except wake, init, sleep bits.
// R15: Reads any time; writes only outside init, except init request.
// R16: Error counter reads valid only in sleep or init; writes ignored.
// R17: Software avoids reading the error counter outside sleep or init.
module ccs_top (
  input  wire logic                        REF_CLK,
  input  wire logic                        RST_N,
  input  wire logic                        CLK_EN,
  input  wire logic                        PSEL,
  input  wire logic                        PENABLE,
  input  wire logic                        PWRITE,
  input  wire logic [ccs_pkg::APB_AW-1:0]  PADDR,
  input  wire logic [31:0]                 PWDATA,
  input  wire logic [3:0]                  PSTRB,
  output logic      [31:0]                 PRDATA,
  output logic                             PREADY,
  output logic                             PSLVERR,
  input  wire logic                        RX_FRAME_OK,
  input  wire logic                        RX_ACTIVE,
  input  wire logic                        BUS_SYNCED,
  input  wire logic                        LOOPBACK,
  input  wire logic                        BIT_TICK,
  input  wire logic                        EOF_VALID,
  input  wire logic                        EOF_IS_RX,
  input  wire logic                        INIT_ACK,
  input  wire logic                        SLEEP_ACK,
  input  wire logic                        WAIT_MODE,
  input  wire logic                        CAN_ACTIVITY,
  input  wire logic [ccs_pkg::ERR_W-1:0]   ERR_COUNT,
  output logic                             INIT_REQ,
  output logic                             SLEEP_REQ,
  output logic                             WAKE_REQ,
  output logic                             BUS_CLK_STOP,
  output logic                             TS_WE,
  output logic      [ccs_pkg::TMR_W-1:0]   TS_DATA,
  output logic                             IRQ
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                         siw;
    logic                         ten;
    logic                         wup;
    logic                         ini;
    logic                         slp;
    logic                         wup_lat;
    logic [31:0]                  prdata;
    logic                         pslverr;
    logic                         ts_we;
    logic [ccs_pkg::TMR_W-1:0]    ts_data;
    logic                         wake;
    logic [ccs_pkg::IRQ_W-1:0]    imsk;
  } ccs_st_t;

  ccs_st_t                        st_r;
  ccs_st_t                        st_nxt;
  ccs_pkg::ccs_mode_t             mode_now;

  logic                           in_init_hold;
  logic                           wr_lock;
  logic                           setup_ph;
  logic                           wr_acc;
  logic                           wr_cs0;
  logic                           wr_ist;
  logic                           addr_hit;
  logic [31:0]                    rd_val;
  logic [7:0]                     cs0_val;
  logic                           frm_flag;
  logic                           frm_set;
  logic                           frm_clr;
  logic                           rxa_view;
  logic                           syn_view;
  logic                           siw_view;
  logic                           ten_view;
  logic                           ts_event;
  logic                           wake_event;
  logic [ccs_pkg::IRQ_W-1:0]      ist_flags;
  logic [ccs_pkg::IRQ_W-1:0]      ist_set;
  logic [ccs_pkg::IRQ_W-1:0]      ist_clr;

  ccs_tmr_if                      tif ();

  // ----------------------------------------------------------------
  // Mode decode and write access
  // ----------------------------------------------------------------
  assign in_init_hold = st_r.ini & INIT_ACK; // see R14
  // Writes stay locked until both request and acknowledge are back at
  // zero, so a half-finished exit cannot corrupt the configuration.
  assign wr_lock  = st_r.ini | INIT_ACK; // see R15
  assign setup_ph = PSEL & ~PENABLE;
  assign wr_acc   = PSEL & PENABLE & PWRITE & PSTRB[0];
  assign wr_cs0   = wr_acc & (PADDR == ccs_pkg::OFF_CS0);
  assign wr_ist   = wr_acc & (PADDR == ccs_pkg::OFF_IST);

  always_comb
  begin
    if (st_r.ini & INIT_ACK)
      mode_now = ccs_pkg::MD_INIT;
    else if (st_r.slp & SLEEP_ACK)
      mode_now = ccs_pkg::MD_SLEEP;
    else
      mode_now = ccs_pkg::MD_RUN;
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Loopback traffic is not counted as reception; the flags are
  // meaningless there and staying quiet is the least surprising choice.
  assign frm_set  = RX_FRAME_OK & ~LOOPBACK; // see R01 see R04
  assign frm_clr  = wr_cs0 & ~wr_lock & PWDATA[ccs_pkg::BIT_FRM]; // see R02 see R15
  assign rxa_view = RX_ACTIVE & ~LOOPBACK & ~in_init_hold; // see R03 see R04
  assign syn_view = BUS_SYNCED & ~in_init_hold; // see R06
  // The hold acts on reads, the timer and the clock gate at once; the
  // flops themselves are cleared one edge later.
  assign siw_view = st_r.siw & ~in_init_hold; // see R14
  assign ten_view = st_r.ten & ~in_init_hold; // see R11

  ccs_sticky #(
    .W     (1)
  ) u_frm (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .ce    (CLK_EN),
    .hold  (in_init_hold),
    .set   (frm_set),
    .clr   (frm_clr),
    .flags (frm_flag)
  );

  always_comb
  begin
    cs0_val                   = 8'h00;
    cs0_val[ccs_pkg::BIT_FRM] = frm_flag & ~in_init_hold; // see R14
    cs0_val[ccs_pkg::BIT_RXA] = rxa_view;
    cs0_val[ccs_pkg::BIT_SIW] = siw_view;
    cs0_val[ccs_pkg::BIT_SYN] = syn_view;
    cs0_val[ccs_pkg::BIT_TEN] = ten_view;
    cs0_val[ccs_pkg::BIT_WUP] = st_r.wup;
    cs0_val[ccs_pkg::BIT_INI] = st_r.ini;
    cs0_val[ccs_pkg::BIT_SLP] = st_r.slp;
  end

  // ----------------------------------------------------------------
  // Timestamp timer
  // ----------------------------------------------------------------
  assign tif.en   = ten_view;
  assign tif.tick = BIT_TICK;

  ccs_timer u_tmr (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .ce    (CLK_EN),
    .tif   (tif)
  );

  assign ts_event = EOF_VALID & ten_view & ~(LOOPBACK & EOF_IS_RX); // see R08 see R09

  // ----------------------------------------------------------------
  // Wake-up and interrupts
  // ----------------------------------------------------------------
  // The enable is frozen when the sleep request bit is set; later changes are ignored.
  assign wake_event = st_r.slp & SLEEP_ACK & st_r.wup_lat & CAN_ACTIVITY; // see R12 see R13

  assign ist_set = {ts_event, wake_event, frm_set};
  assign ist_clr = wr_ist ? PWDATA[ccs_pkg::IRQ_W-1:0] : '0;

  ccs_sticky #(
    .W     (ccs_pkg::IRQ_W)
  ) u_ist (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .ce    (CLK_EN),
    .hold  (1'h0),
    .set   (ist_set),
    .clr   (ist_clr),
    .flags (ist_flags)
  );

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_val   = 32'h0000_0000;
    addr_hit = 1'b1;
    if (PADDR == ccs_pkg::OFF_CS0)
      rd_val[7:0] = cs0_val;
    else if (PADDR == ccs_pkg::OFF_ERR)
    begin
      unique case (mode_now)
        ccs_pkg::MD_INIT,
        ccs_pkg::MD_SLEEP: rd_val[ccs_pkg::ERR_W-1:0] = ERR_COUNT; // see R16
        ccs_pkg::MD_RUN:   rd_val = 32'h0000_0000; // see R17
      endcase
    end
    else if (PADDR == ccs_pkg::OFF_IST)
      rd_val[ccs_pkg::IRQ_W-1:0] = ist_flags;
    else if (PADDR == ccs_pkg::OFF_IMSK)
      rd_val[ccs_pkg::IRQ_W-1:0] = st_r.imsk;
    else if (PADDR == ccs_pkg::OFF_TMR)
      rd_val[ccs_pkg::TMR_W-1:0] = tif.cnt;
    else
      addr_hit = 1'b0;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.ts_we = ts_event;
    st_nxt.wake  = wake_event;
    if (ts_event)
      st_nxt.ts_data = tif.cnt; // see R08
    if (setup_ph)
    begin
      st_nxt.prdata  = rd_val; // see R15
      st_nxt.pslverr = ~addr_hit;
    end
    if (!st_r.slp)
      st_nxt.wup_lat = st_r.wup; // see R13
    if (wr_cs0)
    begin
      st_nxt.ini = PWDATA[ccs_pkg::BIT_INI]; // see R15
      if (!wr_lock)
      begin
        st_nxt.siw = PWDATA[ccs_pkg::BIT_SIW];
        st_nxt.ten = PWDATA[ccs_pkg::BIT_TEN];
        st_nxt.wup = PWDATA[ccs_pkg::BIT_WUP];
        st_nxt.slp = PWDATA[ccs_pkg::BIT_SLP];
      end
    end
    if (wr_acc && (PADDR == ccs_pkg::OFF_IMSK))
      st_nxt.imsk = PWDATA[ccs_pkg::IRQ_W-1:0];
    if (wake_event)
      st_nxt.slp = 1'b0; // see R12
    if (in_init_hold)
    begin
      st_nxt.siw = ccs_pkg::CTL_RST; // see R14
      st_nxt.ten = ccs_pkg::CTL_RST; // see R11
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_r      <= '0;
      st_r.imsk <= ccs_pkg::IMSK_RST;
    end
    else if (CLK_EN)
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign PRDATA       = st_r.prdata;
  assign PSLVERR      = st_r.pslverr;
  // The slave answers in the first access cycle unless frozen.
  assign PREADY       = CLK_EN;
  assign INIT_REQ     = st_r.ini;
  assign SLEEP_REQ    = st_r.slp;
  assign WAKE_REQ     = st_r.wake;
  // Only the bus-side gate is requested here; the controller's own
  // clock keeps running, so state survives wait mode unchanged.
  assign BUS_CLK_STOP = WAIT_MODE & siw_view; // see R05
  assign TS_WE        = st_r.ts_we;
  assign TS_DATA      = st_r.ts_data;
  assign IRQ          = |(ist_flags & st_r.imsk);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  frm_set_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R01
    (CLK_EN && RX_FRAME_OK && !LOOPBACK && !in_init_hold) |=> frm_flag)
    else $error("Frame flag not set by a valid frame.");

  frm_keep_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R02
    (CLK_EN && frm_flag && !frm_clr && !in_init_hold) |=> frm_flag)
    else $error("Frame flag dropped without a clear.");

  rxa_read_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R03
    (CLK_EN && setup_ph && (PADDR == ccs_pkg::OFF_CS0))
    |=> (PRDATA[ccs_pkg::BIT_RXA] == $past(RX_ACTIVE && !LOOPBACK && !in_init_hold)))
    else $error("Receiver-active read mismatch.");

  clk_stop_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R05
    (CLK_EN && wr_cs0 && !wr_lock && !in_init_hold && PWDATA[ccs_pkg::BIT_SIW]) ##1
    WAIT_MODE |-> BUS_CLK_STOP)
    else $error("Bus clocks not stopped in wait mode.");

  syn_read_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R06
    (CLK_EN && setup_ph && (PADDR == ccs_pkg::OFF_CS0))
    |=> (PRDATA[ccs_pkg::BIT_SYN] == $past(BUS_SYNCED && !in_init_hold)))
    else $error("Synchronized read mismatch.");

  ts_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R08
    (CLK_EN && EOF_VALID && ten_view && !(LOOPBACK && EOF_IS_RX))
    |=> (TS_WE && (TS_DATA == $past(tif.cnt))))
    else $error("Timestamp not stored after a valid frame.");

  ts_loop_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R09
    (CLK_EN && EOF_VALID && LOOPBACK && EOF_IS_RX) |=> !TS_WE)
    else $error("Receive timestamp written in loopback.");

  ten_init_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R11
    (CLK_EN && in_init_hold) [*2] |-> !st_r.ten && !st_r.siw)
    else $error("Timer enable high in initialization mode.");

  wake_off_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R12
    (CLK_EN && !st_r.wup_lat) |=> !WAKE_REQ)
    else $error("Wake-up raised while disabled.");

  wr_lock_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R15
    (CLK_EN && wr_cs0 && wr_lock && !wake_event)
    |=> ((st_r.wup == $past(st_r.wup)) && (st_r.slp == $past(st_r.slp))))
    else $error("Locked bits changed by a write in initialization.");

  err_gate_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R16
    (CLK_EN && setup_ph && (PADDR == ccs_pkg::OFF_ERR) && (mode_now == ccs_pkg::MD_RUN))
    |=> (PRDATA == 32'h0000_0000) && !PSLVERR)
    else $error("Error counter exposed outside sleep or initialization.");

endmodule
`default_nettype wire

// [bench/ccs_can_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ccs_can_model #(
  parameter logic [ccs_pkg::ERR_W-1:0] ERR_VAL = 8'h5A
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      tick_en,
  input  wire logic                      init_req,
  input  wire logic                      sleep_req,
  output logic                           init_ack,
  output logic                           sleep_ack,
  output logic                           bit_tick,
  output logic [ccs_pkg::ERR_W-1:0]      err_count
);
  // ----------------------------------------------------------------
  // Mode acknowledges and bit clock
  // ----------------------------------------------------------------
  // Acknowledges lag the requests by two cycles, so the block spends time
  // half way into a mode, where its write lock must already hold.
  logic [1:0] ini_d_r;
  logic [1:0] slp_d_r;
  logic [1:0] div_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ini_d_r <= 2'h0;
      slp_d_r <= 2'h0;
      div_r   <= 2'h0;
    end
    else
    begin
      ini_d_r <= {ini_d_r[0], init_req};
      slp_d_r <= {slp_d_r[0], sleep_req};
      div_r   <= tick_en ? div_r + 2'h1 : 2'h0;
    end
  end

  assign init_ack  = ini_d_r[1];
  assign sleep_ack = slp_d_r[1];
  assign bit_tick  = tick_en && (div_r == 2'h3);
  // Outside sleep and init the count is not trustworthy, so it wanders.
  assign err_count = (init_ack || sleep_ack) ? ERR_VAL : {6'h0, div_r} ^ 8'hA5;
endmodule
`default_nettype wire

// [bench/can_control_status_reg0_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module can_control_status_reg0_tb;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic        rx_ok, rx_act, synced, loopback, bit_tick, eof, eof_rx, tick_en;
  logic        init_ack, sleep_ack, wait_md, can_act, init_req, sleep_req;
  logic        wake_req, clk_stop, ts_we, irq, clk_en;
  logic [7:0]  err_cnt;
  logic [15:0] ts_data;
  int          n_tests = 0;
  int          miscompares = 0;

  ccs_top i_dut (
    .REF_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RX_FRAME_OK(rx_ok), .RX_ACTIVE(rx_act),
    .BUS_SYNCED(synced), .LOOPBACK(loopback), .BIT_TICK(bit_tick), .EOF_VALID(eof),
    .EOF_IS_RX(eof_rx), .INIT_ACK(init_ack), .SLEEP_ACK(sleep_ack), .WAIT_MODE(wait_md),
    .CAN_ACTIVITY(can_act), .ERR_COUNT(err_cnt), .INIT_REQ(init_req), .SLEEP_REQ(sleep_req),
    .WAKE_REQ(wake_req), .BUS_CLK_STOP(clk_stop), .TS_WE(ts_we), .TS_DATA(ts_data), .IRQ(irq)
  );

  ccs_can_model i_can (
    .clk(clk), .rst_n(rst_n), .tick_en(tick_en), .init_req(init_req),
    .sleep_req(sleep_req), .init_ack(init_ack), .sleep_ack(sleep_ack),
    .bit_tick(bit_tick), .err_count(err_cnt)
  );

  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // An idle cycle follows each transfer so no strobe is driven twice in one step.
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1)
      @(posedge clk);
    rd_q    = prdata;
    err_q   = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'h1, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    xfer(a, 1'h0, 32'h0);
    check(what, rd_q, exp);
  endtask

  task automatic wait_ack(input logic slp, input logic lvl);
    int i;
    i = 0;
    while ((slp ? sleep_ack : init_ack) !== lvl && i < 20)
    begin
      i++;
      @(posedge clk);
    end
    check("mode acknowledge", slp ? sleep_ack : init_ack, lvl);
  endtask

  task automatic eof_pulse(input logic rx, input logic lb, input logic exp);
    loopback <= lb;
    eof_rx   <= rx;
    eof      <= 1'h1;
    @(posedge clk);
    eof      <= 1'h0;
    #1;
    check("timestamp strobe", ts_we, exp);
    if (exp)
      check("timestamp value", ts_data, 32'h0A);
    @(posedge clk);
  endtask

  task automatic wake_try(input logic exp);
    can_act <= 1'h1;
    @(posedge clk);
    can_act <= 1'h0;
    #1;
    check("wake pulse", wake_req, exp);
    @(posedge clk);
  endtask

  task automatic test_done();
    $display("Checks: %0d, mismatches: %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    {clk, rst_n, psel, penable, pwrite, rx_ok, rx_act, synced} = 8'h0;
    {loopback, eof, eof_rx, tick_en, wait_md, can_act} = 6'h0;
    paddr  = 12'h0;
    pwdata = 32'h0;
    clk_en = 1'h1;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(ccs_pkg::OFF_CS0, 32'h0, "control reset");
    rd(ccs_pkg::OFF_IMSK, 32'h0, "mask reset");
    $display("Test reset values finished");
    rx_ok <= 1'h1;
    @(posedge clk);
    rx_ok <= 1'h0;
    rd(ccs_pkg::OFF_CS0, 32'h80, "frame flag set");
    check("irq masked", irq, 1'h0);
    wr(ccs_pkg::OFF_CS0, 32'h0);
    rd(ccs_pkg::OFF_CS0, 32'h80, "frame flag kept");
    wr(ccs_pkg::OFF_IMSK, 32'h1);
    rd(ccs_pkg::OFF_IST, 32'h1, "frame status");
    check("irq raised", irq, 1'h1);
    wr(ccs_pkg::OFF_IST, 32'h1);
    check("irq cleared", irq, 1'h0);
    wr(ccs_pkg::OFF_CS0, 32'h80);
    rd(ccs_pkg::OFF_CS0, 32'h0, "frame flag cleared");
    loopback <= 1'h1;
    rx_ok    <= 1'h1;
    @(posedge clk);
    rx_ok    <= 1'h0;
    rd(ccs_pkg::OFF_CS0, 32'h0, "frame flag loopback");
    $display("Test frame flag finished");
    loopback <= 1'h0;
    rx_act   <= 1'h1;
    synced   <= 1'h1;
    wr(ccs_pkg::OFF_CS0, 32'h0);
    rd(ccs_pkg::OFF_CS0, 32'h50, "active and synced");
    rx_act <= 1'h0;
    @(posedge clk);
    rd(ccs_pkg::OFF_CS0, 32'h10, "synced only");
    wait_md <= 1'h1;
    wr(ccs_pkg::OFF_CS0, 32'h20);
    check("clock stop", clk_stop, 1'h1);
    wr(ccs_pkg::OFF_CS0, 32'h0);
    check("clock run", clk_stop, 1'h0);
    wait_md <= 1'h0;
    $display("Test status and wait finished");
    wr(ccs_pkg::OFF_CS0, 32'h08);
    tick_en <= 1'h1;
    repeat (40) @(posedge clk);
    tick_en <= 1'h0;
    repeat (2) @(posedge clk);
    rd(ccs_pkg::OFF_TMR, 32'h0A, "timer count");
    eof_pulse(1'h0, 1'h0, 1'h1);
    eof_pulse(1'h1, 1'h0, 1'h1);
    eof_pulse(1'h1, 1'h1, 1'h0);
    rd(ccs_pkg::OFF_IST, 32'h4, "timestamp status");
    wr(ccs_pkg::OFF_IST, 32'h4);
    loopback <= 1'h0;
    wr(ccs_pkg::OFF_CS0, 32'h0);
    rd(ccs_pkg::OFF_TMR, 32'h0, "timer cleared");
    eof_pulse(1'h0, 1'h0, 1'h0);
    $display("Test timer finished");
    wr(ccs_pkg::OFF_CS0, 32'h2C);
    wr(ccs_pkg::OFF_CS0, 32'h2E);
    wait_ack(1'h0, 1'h1);
    rd(ccs_pkg::OFF_CS0, 32'h06, "init hold");
    rd(ccs_pkg::OFF_TMR, 32'h0, "timer in init");
    wr(ccs_pkg::OFF_CS0, 32'h2A);
    rd(ccs_pkg::OFF_CS0, 32'h06, "init write lock");
    rd(ccs_pkg::OFF_ERR, 32'h5A, "error count init");
    wr(ccs_pkg::OFF_ERR, 32'hFF);
    rd(ccs_pkg::OFF_ERR, 32'h5A, "error count write");
    wr(ccs_pkg::OFF_CS0, 32'h04);
    wait_ack(1'h0, 1'h0);
    wr(ccs_pkg::OFF_CS0, 32'h24);
    rd(ccs_pkg::OFF_CS0, 32'h34, "writable after init");
    $display("Test init mode finished");
    wr(ccs_pkg::OFF_IMSK, 32'h2);
    wr(ccs_pkg::OFF_CS0, 32'h05);
    wait_ack(1'h1, 1'h1);
    rd(ccs_pkg::OFF_ERR, 32'h5A, "error count sleep");
    wake_try(1'h1);
    rd(ccs_pkg::OFF_CS0, 32'h14, "woken");
    check("irq wake", irq, 1'h1);
    rd(ccs_pkg::OFF_IST, 32'h2, "wake status");
    wr(ccs_pkg::OFF_IST, 32'h2);
    check("irq wake cleared", irq, 1'h0);
    wait_ack(1'h1, 1'h0);
    wr(ccs_pkg::OFF_CS0, 32'h0);
    wr(ccs_pkg::OFF_CS0, 32'h01);
    wait_ack(1'h1, 1'h1);
    wake_try(1'h0);
    rd(ccs_pkg::OFF_CS0, 32'h11, "still asleep");
    wr(ccs_pkg::OFF_CS0, 32'h0);
    $display("Test sleep and wake finished");
    clk_en <= 1'h0;
    rx_ok  <= 1'h1;
    @(posedge clk);
    check("ready frozen", pready, 1'h0);
    rx_ok  <= 1'h0;
    clk_en <= 1'h1;
    rd(ccs_pkg::OFF_CS0, 32'h10, "frozen frame flag");
    $display("Test clock enable finished");
    xfer(12'h0FC, 1'h0, 32'h0);
    check("unmapped error", err_q, 1'h1);
    check("unmapped data", rd_q, 32'h0);
    $display("Test unmapped finished");
    test_done();
  end

  initial
  begin
    #50000;
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
